// [pg_top.sv]
// three-unit pwm block with output control and axi4-lite registers
`include "pg_regs.svh"
`default_nettype none
// Contract
// - count-down: start at load, decrement to zero, reload, repeat
// - up/down: count zero up to load and back down, repeat
// - direction low in count-down; low rising, high falling in up/down
// - one-cycle zero pulse at zero, load pulse at load value
// - count-down: load pulse follows zero pulse next cycle
// - two comparators pulse on match, split up/down in up/down mode
// - compare value above load never matches
// - four events in count-down, six in up/down drive the outputs
// - matches coinciding with zero or load are ignored
// - on coinciding matches first output uses A, second uses B
// - per event and output: ignore, toggle, drive low, drive high
// - dead-band disabled passes both outputs unchanged
// - dead-band first output: input with rising edge delayed
// - dead-band second output: inverted input, rise delayed after fall
// - selectable event sets fire interrupt and adc trigger
// - interrupt and trigger use raw events, not dead-band edges
// - global sync restarts chosen counters: zero in up/down, load value in count-down; software aligns loads first
// - immediate update applies new values at next counter zero
// - synchronous update waits for global update, then next zero
// - fault forces fault-enabled outputs inactive; fault may interrupt
// - debug stall: stop at zero or keep running; no interrupt
// - shared enable register gates six outputs; optional inversion
module pg_top #(
  parameter int CNT_W = 16,
  parameter int DB_W = 12,
  parameter int NGEN = 3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire pg_pkg::pg_axi_req_t axi_req,
  output pg_pkg::pg_axi_rsp_t axi_rsp,
  input wire logic fault_pin,
  input wire logic dbg_stall,
  output logic [2*NGEN-1:0] pwm_out,
  output logic [NGEN-1:0] adc_trig,
  output logic irq
);
  localparam int NOUT = 2 * NGEN;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic act_next(input logic cur, input logic [1:0] act);
    case (pg_pkg::pg_act_t'(act))
      pg_pkg::PG_ACT_TOGGLE: return !cur;
      pg_pkg::PG_ACT_LOW: return 1'b0;
      pg_pkg::PG_ACT_HIGH: return 1'b1;
      default: return cur;
    endcase
  endfunction

  // picks the action of the highest event; b_first swaps match priority
  function automatic logic [1:0] pick(input logic [`PG_EV_NUM-1:0] ev,
                                      input logic [`PG_ACT_W-1:0] gen,
                                      input logic b_first);
    logic [1:0] a_act;
    logic [1:0] b_act;
    a_act = ev[`PG_EV_AUP] ? gen[5:4] :
            ev[`PG_EV_ADN] ? gen[7:6] : 2'b00;
    b_act = ev[`PG_EV_BUP] ? gen[9:8] :
            ev[`PG_EV_BDN] ? gen[11:10] : 2'b00;
    if (ev[`PG_EV_ZERO]) begin
      return gen[1:0];
    end else if (ev[`PG_EV_LOAD]) begin
      return gen[3:2];
    end else if (b_first) begin
      return (b_act != 2'b00 || !(ev[`PG_EV_BUP] | ev[`PG_EV_BDN])) ?
             (|(ev[`PG_EV_BDN:`PG_EV_BUP]) ? b_act : a_act) : b_act;
    end else begin
      return (|(ev[`PG_EV_ADN:`PG_EV_AUP])) ? a_act : b_act;
    end
  endfunction

  // axi4-lite slave state
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [pg_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rd_d;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic rd_err, wr_err, wr_fire;
  logic [5:0] wr_slot, rd_slot;
  logic [5:0] wr_off, rd_off;
  logic [1:0] rd_gi;

  // global registers
  logic [NOUT-1:0] enable_q, invert_q, faulten_q;
  logic [NGEN-1:0] inten_q, gen_irq;
  logic fault_inten_q, fault_ris_q;
  logic fault_s1_q, fault_s2_q;
  logic [NGEN-1:0] sync_rst, glob_upd;
  logic [NOUT-1:0] db_out;

  // per-unit registers
  logic [`PG_GCTL_W-1:0] gctl_q [NGEN];
  logic [`PG_GEN_INTEN_W-1:0] ginten_q [NGEN];
  logic [`PG_EV_NUM-1:0] gris_q [NGEN];
  logic [CNT_W-1:0] load_sh_q [NGEN];
  logic [CNT_W-1:0] cmpa_sh_q [NGEN];
  logic [CNT_W-1:0] cmpb_sh_q [NGEN];
  logic [CNT_W-1:0] load_q [NGEN];
  logic [CNT_W-1:0] cmpa_q [NGEN];
  logic [CNT_W-1:0] cmpb_q [NGEN];
  logic [CNT_W-1:0] cnt_q [NGEN];
  logic [`PG_ACT_W-1:0] gena_q [NGEN];
  logic [`PG_ACT_W-1:0] genb_q [NGEN];
  logic dben_q [NGEN];
  logic [DB_W-1:0] dbr_q [NGEN];
  logic [DB_W-1:0] dbf_q [NGEN];

  assign axi_rsp.awready = !aw_held_q && !bvalid_q;
  assign axi_rsp.wready = !w_held_q && !bvalid_q;
  assign axi_rsp.bvalid = bvalid_q;
  assign axi_rsp.bresp = bresp_q;
  assign axi_rsp.arready = !rvalid_q;
  assign axi_rsp.rvalid = rvalid_q;
  assign axi_rsp.rdata = rdata_q;
  assign axi_rsp.rresp = rresp_q;

  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_slot = awaddr_q[`PG_SLOT_MSB:`PG_SLOT_LSB];
  assign wr_off = awaddr_q[`PG_OFF_MSB:0];
  assign wr_err = !(wr_slot <= 6'(NGEN));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= `PG_RESP_OKAY;
    end else begin
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_held_q <= 1'b1;
        wdata_q <= axi_req.wdata;
        wstrb_q <= axi_req.wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_err ? `PG_RESP_SLVERR : `PG_RESP_OKAY;
      end else if (bvalid_q && axi_req.bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // global write pulses: counter sync and synchronised update
  always_comb begin
    sync_rst = '0;
    glob_upd = '0;
    if (wr_fire && wr_slot == `PG_GLB_SLOT && wstrb_q[0]) begin
      if (wr_off == `PG_OFF_SYNC) begin
        sync_rst = wdata_q[NGEN-1:0];
      end
      if (wr_off == `PG_OFF_CTL) begin
        glob_upd = wdata_q[NGEN-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      enable_q <= '0;
      invert_q <= '0;
      faulten_q <= '0;
      inten_q <= '0;
      fault_inten_q <= 1'b0;
    end else if (wr_fire && wr_slot == `PG_GLB_SLOT) begin
      case (wr_off)
        `PG_OFF_ENABLE: enable_q <= NOUT'(merge(32'(enable_q), wdata_q,
                                                wstrb_q));
        `PG_OFF_INVERT: invert_q <= NOUT'(merge(32'(invert_q), wdata_q,
                                                wstrb_q));
        `PG_OFF_FAULT: faulten_q <= NOUT'(merge(32'(faulten_q), wdata_q,
                                                wstrb_q));
        `PG_OFF_INTEN: begin
          if (wstrb_q[0]) begin
            inten_q <= wdata_q[NGEN-1:0];
          end
          if (wstrb_q[2]) begin
            fault_inten_q <= wdata_q[`PG_INTEN_FAULT];
          end
        end
        default: ;
      endcase
    end
  end

  // fault pin crosses in through two flops
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fault_s1_q <= 1'b0;
      fault_s2_q <= 1'b0;
      fault_ris_q <= 1'b0;
    end else begin
      fault_s1_q <= fault_pin;
      fault_s2_q <= fault_s1_q;
      if (fault_s2_q) begin
        fault_ris_q <= 1'b1;
      end else if (wr_fire && wr_slot == `PG_GLB_SLOT &&
                   wr_off == `PG_OFF_ISC && wstrb_q[2] &&
                   wdata_q[`PG_INTEN_FAULT]) begin
        fault_ris_q <= 1'b0;
      end
    end
  end

  // the debug stall is never a source here
  assign irq = |(gen_irq & inten_q) | (fault_ris_q & fault_inten_q);

  for (genvar g = 0; g < NGEN; g++) begin : gen_unit
    logic [`PG_EV_NUM-1:0] ev;
    logic run, mat_a, mat_b, updn, apply, upd_pend_q, wr_me;
    logic raw_a_q, raw_b_q;
    pg_pkg::pg_dir_t dir_q;
    logic [CNT_W-1:0] load_nx;

    assign wr_me = wr_fire && wr_slot == 6'(g + 1);
    assign updn = gctl_q[g][`PG_GCTL_UPDN];
    // a stop-at-zero stall freezes the counter once it sits at zero
    assign run = gctl_q[g][`PG_GCTL_EN] &&
                 !(dbg_stall && !gctl_q[g][`PG_GCTL_DBGRUN] &&
                   cnt_q[g] == '0);
    assign mat_a = run && cnt_q[g] == cmpa_q[g] &&
                   cmpa_q[g] <= load_q[g];
    assign mat_b = run && cnt_q[g] == cmpb_q[g] &&
                   cmpb_q[g] <= load_q[g];
    assign ev[`PG_EV_ZERO] = run && cnt_q[g] == '0;
    assign ev[`PG_EV_LOAD] = run && cnt_q[g] == load_q[g];
    assign ev[`PG_EV_AUP] = mat_a && updn &&
                            dir_q == pg_pkg::PG_DIR_UP;
    assign ev[`PG_EV_ADN] = mat_a && (!updn ||
                            dir_q == pg_pkg::PG_DIR_DOWN);
    assign ev[`PG_EV_BUP] = mat_b && updn &&
                            dir_q == pg_pkg::PG_DIR_UP;
    assign ev[`PG_EV_BDN] = mat_b && (!updn ||
                            dir_q == pg_pkg::PG_DIR_DOWN);
    assign apply = ev[`PG_EV_ZERO] &&
                   (!gctl_q[g][`PG_GCTL_SYNCUPD] || upd_pend_q);
    assign load_nx = apply ? load_sh_q[g] : load_q[g];
    assign gen_irq[g] = |gris_q[g];

    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        gctl_q[g] <= '0;
        ginten_q[g] <= '0;
        load_sh_q[g] <= '0;
        cmpa_sh_q[g] <= '0;
        cmpb_sh_q[g] <= '0;
        gena_q[g] <= '0;
        genb_q[g] <= '0;
        dben_q[g] <= 1'b0;
        dbr_q[g] <= '0;
        dbf_q[g] <= '0;
      end else if (wr_me) begin
        case (wr_off)
          `PG_G_CTL: gctl_q[g] <= wdata_q[`PG_GCTL_W-1:0];
          `PG_G_INTEN: ginten_q[g] <= wdata_q[`PG_GEN_INTEN_W-1:0];
          `PG_G_LOAD: load_sh_q[g] <= CNT_W'(merge(32'(load_sh_q[g]),
                                                   wdata_q, wstrb_q));
          `PG_G_CMPA: cmpa_sh_q[g] <= CNT_W'(merge(32'(cmpa_sh_q[g]),
                                                   wdata_q, wstrb_q));
          `PG_G_CMPB: cmpb_sh_q[g] <= CNT_W'(merge(32'(cmpb_sh_q[g]),
                                                   wdata_q, wstrb_q));
          `PG_G_GENA: gena_q[g] <= wdata_q[`PG_ACT_W-1:0];
          `PG_G_GENB: genb_q[g] <= wdata_q[`PG_ACT_W-1:0];
          `PG_G_DBCTL: dben_q[g] <= wdata_q[0];
          `PG_G_DBRISE: dbr_q[g] <= wdata_q[DB_W-1:0];
          `PG_G_DBFALL: dbf_q[g] <= wdata_q[DB_W-1:0];
          default: ;
        endcase
      end
    end

    // shadow values move to the active set at a counter zero, and every cycle while the unit is disabled
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        load_q[g] <= '0;
        cmpa_q[g] <= '0;
        cmpb_q[g] <= '0;
        upd_pend_q <= 1'b0;
      end else if (!gctl_q[g][`PG_GCTL_EN]) begin
        load_q[g] <= load_sh_q[g];
        cmpa_q[g] <= cmpa_sh_q[g];
        cmpb_q[g] <= cmpb_sh_q[g];
        upd_pend_q <= 1'b0;
      end else begin
        if (apply) begin
          load_q[g] <= load_sh_q[g];
          cmpa_q[g] <= cmpa_sh_q[g];
          cmpb_q[g] <= cmpb_sh_q[g];
        end
        upd_pend_q <= glob_upd[g] || (upd_pend_q && !apply);
      end
    end

    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        cnt_q[g] <= '0;
        dir_q <= pg_pkg::PG_DIR_UP;
      end else if (!gctl_q[g][`PG_GCTL_EN] || sync_rst[g]) begin
        cnt_q[g] <= updn ? '0 : load_nx;
        dir_q <= pg_pkg::PG_DIR_UP;
      end else if (run && !updn) begin
        dir_q <= pg_pkg::PG_DIR_UP;
        cnt_q[g] <= (cnt_q[g] == '0) ? load_nx : cnt_q[g] - 1'b1;
      end else if (run && dir_q == pg_pkg::PG_DIR_UP) begin
        if (cnt_q[g] >= load_q[g]) begin
          dir_q <= pg_pkg::PG_DIR_DOWN;
          cnt_q[g] <= (cnt_q[g] == '0) ? '0 : cnt_q[g] - 1'b1;
        end else begin
          cnt_q[g] <= cnt_q[g] + 1'b1;
        end
      end else if (run) begin
        if (cnt_q[g] == '0) begin
          dir_q <= pg_pkg::PG_DIR_UP;
          cnt_q[g] <= (load_nx == '0) ? '0 : CNT_W'(1);
        end else begin
          cnt_q[g] <= cnt_q[g] - 1'b1;
        end
      end
    end

    always_ff @(posedge ref_clk) begin
      if (!rst_n || !gctl_q[g][`PG_GCTL_EN]) begin
        raw_a_q <= 1'b0;
        raw_b_q <= 1'b0;
      end else begin
        raw_a_q <= act_next(raw_a_q, pick(ev, gena_q[g], 1'b0));
        raw_b_q <= act_next(raw_b_q, pick(ev, genb_q[g], 1'b1));
      end
    end

    // status and trigger come from the raw events
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        gris_q[g] <= '0;
        adc_trig[g] <= 1'b0;
      end else begin
        gris_q[g] <= (gris_q[g] & ~((wr_me && wr_off == `PG_G_ISC &&
                     wstrb_q[0]) ? wdata_q[`PG_EV_NUM-1:0] : '0)) |
                     (ev & ginten_q[g][`PG_EV_NUM-1:0]);
        adc_trig[g] <= |(ev & ginten_q[g][`PG_INTEN_TRIG_LSB +:
                                           `PG_EV_NUM]);
      end
    end

    pg_deadband #(
      .DB_W(DB_W)
    ) u_db (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .db_en(dben_q[g]),
      .rise_dly(dbr_q[g]),
      .fall_dly(dbf_q[g]),
      .in_a(raw_a_q),
      .in_b(raw_b_q),
      .out_a(db_out[2*g]),
      .out_b(db_out[2*g+1])
    );
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwm_out <= '0;
    end else begin
      pwm_out <= invert_q ^ (enable_q & db_out &
                 ~(faulten_q & {NOUT{fault_s2_q}}));
    end
  end

  assign rd_slot = axi_req.araddr[`PG_SLOT_MSB:`PG_SLOT_LSB];
  assign rd_off = axi_req.araddr[`PG_OFF_MSB:0];
  assign rd_gi = 2'(rd_slot - 6'h01);

  always_comb begin
    rd_d = '0;
    rd_err = 1'b0;
    if (rd_slot == `PG_GLB_SLOT) begin
      case (rd_off)
        `PG_OFF_CTL, `PG_OFF_SYNC, `PG_OFF_ISC: rd_d = '0;
        `PG_OFF_ENABLE: rd_d = 32'(enable_q);
        `PG_OFF_INVERT: rd_d = 32'(invert_q);
        `PG_OFF_FAULT: rd_d = 32'(faulten_q);
        `PG_OFF_INTEN: rd_d = 32'(inten_q) |
                              (32'(fault_inten_q) << `PG_INTEN_FAULT);
        `PG_OFF_RIS: rd_d = 32'(gen_irq) |
                            (32'(fault_ris_q) << `PG_INTEN_FAULT);
        `PG_OFF_STATUS: rd_d = 32'(fault_s2_q);
        default: rd_err = 1'b1;
      endcase
    end else if (rd_slot <= 6'(NGEN)) begin
      case (rd_off)
        `PG_G_CTL: rd_d = 32'(gctl_q[rd_gi]);
        `PG_G_INTEN: rd_d = 32'(ginten_q[rd_gi]);
        `PG_G_RIS, `PG_G_ISC: rd_d = 32'(gris_q[rd_gi]);
        `PG_G_LOAD: rd_d = 32'(load_sh_q[rd_gi]);
        `PG_G_COUNT: rd_d = 32'(cnt_q[rd_gi]);
        `PG_G_CMPA: rd_d = 32'(cmpa_sh_q[rd_gi]);
        `PG_G_CMPB: rd_d = 32'(cmpb_sh_q[rd_gi]);
        `PG_G_GENA: rd_d = 32'(gena_q[rd_gi]);
        `PG_G_GENB: rd_d = 32'(genb_q[rd_gi]);
        `PG_G_DBCTL: rd_d = 32'(dben_q[rd_gi]);
        `PG_G_DBRISE: rd_d = 32'(dbr_q[rd_gi]);
        `PG_G_DBFALL: rd_d = 32'(dbf_q[rd_gi]);
        default: rd_err = 1'b1;
      endcase
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `PG_RESP_OKAY;
    end else if (axi_req.arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_d;
      rresp_q <= rd_err ? `PG_RESP_SLVERR : `PG_RESP_OKAY;
    end else if (rvalid_q && axi_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule // pg_top
`default_nettype wire

// [pg_regs.svh]
// register offsets, field positions and response codes of the pwm block
`ifndef PG_REGS_SVH
`define PG_REGS_SVH
`define PG_SLOT_MSB 11
`define PG_SLOT_LSB 6
`define PG_OFF_MSB 5
`define PG_GLB_SLOT 6'h00
`define PG_OFF_CTL 6'h00
`define PG_OFF_SYNC 6'h04
`define PG_OFF_ENABLE 6'h08
`define PG_OFF_INVERT 6'h0c
`define PG_OFF_FAULT 6'h10
`define PG_OFF_INTEN 6'h14
`define PG_OFF_RIS 6'h18
`define PG_OFF_ISC 6'h1c
`define PG_OFF_STATUS 6'h20
`define PG_G_CTL 6'h00
`define PG_G_INTEN 6'h04
`define PG_G_RIS 6'h08
`define PG_G_ISC 6'h0c
`define PG_G_LOAD 6'h10
`define PG_G_COUNT 6'h14
`define PG_G_CMPA 6'h18
`define PG_G_CMPB 6'h1c
`define PG_G_GENA 6'h20
`define PG_G_GENB 6'h24
`define PG_G_DBCTL 6'h28
`define PG_G_DBRISE 6'h2c
`define PG_G_DBFALL 6'h30
`define PG_GCTL_EN 0
`define PG_GCTL_UPDN 1
`define PG_GCTL_DBGRUN 2
`define PG_GCTL_SYNCUPD 3
`define PG_GCTL_W 4
`define PG_EV_ZERO 0
`define PG_EV_LOAD 1
`define PG_EV_AUP 2
`define PG_EV_ADN 3
`define PG_EV_BUP 4
`define PG_EV_BDN 5
`define PG_EV_NUM 6
`define PG_INTEN_TRIG_LSB 8
`define PG_GEN_INTEN_W 14
`define PG_INTEN_FAULT 16
`define PG_ACT_W 12
`define PG_RESP_OKAY 2'b00
`define PG_RESP_SLVERR 2'b10
`endif

// [pg_pkg.sv]
// types shared by the pwm block
`default_nettype none
package pg_pkg;
  localparam int ADDR_W = 12;
  typedef enum logic [1:0] {
    PG_ACT_NONE = 2'b00,
    PG_ACT_TOGGLE = 2'b01,
    PG_ACT_LOW = 2'b10,
    PG_ACT_HIGH = 2'b11
  } pg_act_t;
  typedef enum logic {
    PG_DIR_UP = 1'b0,
    PG_DIR_DOWN = 1'b1
  } pg_dir_t;
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } pg_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pg_axi_rsp_t;
endpackage
`default_nettype wire

// [pg_deadband.sv]
// dead-band generator of one pwm unit
`default_nettype none
module pg_deadband #(
  parameter int DB_W = 12
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic db_en,
  input wire logic [DB_W-1:0] rise_dly,
  input wire logic [DB_W-1:0] fall_dly,
  input wire logic in_a,
  input wire logic in_b,
  output logic out_a,
  output logic out_b
);
  logic [DB_W-1:0] rise_cnt_q;
  logic [DB_W-1:0] fall_cnt_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_a <= 1'b0;
      rise_cnt_q <= '0;
    end else if (!db_en) begin
      out_a <= in_a;
      rise_cnt_q <= '0;
    end else if (!in_a) begin
      out_a <= 1'b0;
      rise_cnt_q <= '0;
    end else if (rise_cnt_q >= rise_dly) begin
      out_a <= 1'b1;
    end else begin
      rise_cnt_q <= rise_cnt_q + 1'b1;
    end
  end

  // second input is dropped while dead-band is on
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_b <= 1'b0;
      fall_cnt_q <= '0;
    end else if (!db_en) begin
      out_b <= in_b;
      fall_cnt_q <= '0;
    end else if (in_a) begin
      out_b <= 1'b0;
      fall_cnt_q <= '0;
    end else if (fall_cnt_q >= fall_dly) begin
      out_b <= 1'b1;
    end else begin
      fall_cnt_q <= fall_cnt_q + 1'b1;
    end
  end
endmodule // pg_deadband
`default_nettype wire

// [pg_chk.sv]
// port-level assertions of the pwm block
`default_nettype none
module pg_chk #(
  parameter int NGEN = 3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire pg_pkg::pg_axi_req_t axi_req,
  input wire pg_pkg::pg_axi_rsp_t axi_rsp,
  input wire logic fault_pin,
  input wire logic dbg_stall,
  input wire logic [2*NGEN-1:0] pwm_out,
  input wire logic [NGEN-1:0] adc_trig,
  input wire logic irq
);
  logic [2*NGEN-1:0] en_q;
  logic [2*NGEN-1:0] inv_q;
  logic wr_take;
  assign wr_take = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
    && axi_rsp.wready;
  // shadows of the shared enable and invert registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      en_q <= '0;
      inv_q <= '0;
    end else if (wr_take && axi_req.awaddr == 12'h008) begin
      en_q <= axi_req.wdata[2*NGEN-1:0];
    end else if (wr_take && axi_req.awaddr == 12'h00c) begin
      inv_q <= axi_req.wdata[2*NGEN-1:0];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_reset_quiet: assert property (
    $rose(rst_n) |-> pwm_out == '0 && adc_trig == '0 && !irq)
    else $error("outputs not cleared by reset");
  a_enable_gate: assert property (
    ((pwm_out ^ $past(inv_q, 2)) & ~$past(en_q, 2)) == '0)
    else $error("disabled output driven");
  a_wr_answer: assert property (wr_take |-> ##2 axi_rsp.bvalid)
    else $error("write not answered");
  a_rd_answer: assert property (
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read not answered");
  a_b_hold: assert property (axi_rsp.bvalid && !axi_req.bready
    |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
  a_r_hold: assert property (axi_rsp.rvalid && !axi_req.rready
    |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");
  a_r_block: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken while answering");
  a_b_block: assert property (
    axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while answering");
  c_trig: cover property (adc_trig[0]);
  c_irq: cover property (irq);
  c_stall: cover property (dbg_stall && |pwm_out);
endmodule // pg_chk
bind pg_top pg_chk #(.NGEN(NGEN)) u_chk (.ref_clk, .rst_n, .axi_req,
  .axi_rsp, .fault_pin, .dbg_stall, .pwm_out, .adc_trig, .irq);
`default_nettype wire

// [pg_gate_model.sv]
// gate driver and adc sequencer stand-in at the pwm outputs
`default_nettype none
module pg_gate_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [5:0] pwm_out,
  input wire logic [2:0] adc_trig,
  output logic [15:0] trig_cnt,
  output logic shoot_q
);
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      trig_cnt <= '0;
      shoot_q <= 1'b0;
    end else begin
      trig_cnt <= trig_cnt + 16'(adc_trig[0]);
      shoot_q <= shoot_q | (pwm_out[4] & pwm_out[5]);
    end
  end
endmodule // pg_gate_model
`default_nettype wire

// [tb_pwm_generator_module.sv]
// self-checking bench of the pwm block
`default_nettype none
module tb_pwm_generator_module;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk;
  logic rst_n;
  logic fault_pin;
  logic dbg_stall;
  pg_pkg::pg_axi_req_t req;
  pg_pkg::pg_axi_rsp_t rsp;
  logic [5:0] pwm_out;
  logic [2:0] adc_trig;
  logic irq;
  logic [15:0] trig_cnt;
  logic shoot_q;
  logic [34:0] rq[$];
  logic [1:0] bq[$];
  logic [34:0] e;
  logic [31:0] rv;
  logic [15:0] t0;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 32'h622729ee;
  logic [31:0] hi;
  logic [31:0] ri;
  logic [43:0] cfg [21] = '{44'h05000000009, 44'h05800000004,
    44'h05c0000000c, 44'h06000000083, 44'h06400000803, 44'h04400000100,
    44'h04000000001, 44'h09000000008, 44'h09800000003, 44'h09c00000008,
    44'h0a0000000b0, 44'h0a40000050c, 44'h08000000003, 44'h0d000000009,
    44'h0d800000004, 44'h0e000000083, 44'h0e800000001, 44'h0ec00000002,
    44'h0f000000003, 44'h0c000000001, 44'h0080000003f};

  pg_top uut (.ref_clk, .rst_n, .axi_req(req), .axi_rsp(rsp), .fault_pin,
    .dbg_stall, .pwm_out, .adc_trig, .irq);
  pg_gate_model u_gate (.ref_clk, .rst_n, .pwm_out, .adc_trig, .trig_cnt,
    .shoot_q);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    bq.push_back(r);
    req.awaddr <= a;
    req.wdata <= d;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge ref_clk);
      ad = ad | rsp.awready;
      wd = wd | rsp.wready;
      req.awvalid <= !ad;
      req.wvalid <= !wd;
    end
    do @(posedge ref_clk); while (!rsp.bvalid);
    req.bready <= 1'b1;
    @(posedge ref_clk);
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] r, input logic m);
    rq.push_back({m, r, d});
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do @(posedge ref_clk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rsp.rvalid);
    req.rready <= 1'b1;
    @(posedge ref_clk);
    req.rready <= 1'b0;
  endtask

  // counts high cycles and rising edges of one output
  task automatic meas(input int b, input int n);
    logic p;
    hi = 0;
    ri = 0;
    p = pwm_out[b];
    repeat (n) begin
      @(negedge ref_clk);
      hi += 32'(pwm_out[b]);
      ri += 32'(pwm_out[b] && !p);
      p = pwm_out[b];
    end
    @(posedge ref_clk);
  endtask

  // response watcher: takes the oldest note at each answer
  always @(posedge ref_clk) begin
    if (rsp.bvalid && req.bready) begin
      check({30'h0, rsp.bresp}, {30'h0, bq.pop_front()});
    end
    if (rsp.rvalid && req.rready) begin
      e = rq.pop_front();
      check({30'h0, rsp.rresp}, {30'h0, e[33:32]});
      if (e[34]) begin
        check(rsp.rdata, e[31:0]);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    summarize();
  end

  initial begin
    req = '{wstrb: 4'hf, default: '0};
    rst_n = 1'b0;
    fault_pin = 1'b0;
    dbg_stall = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (cfg[i]) begin
      wr(cfg[i][43:32], cfg[i][31:0], 2'b00);
    end
    repeat (30) @(posedge ref_clk);
    t0 = trig_cnt;
    meas(0, 40);
    check(hi, 24);
    check(ri, 4);
    check(32'(trig_cnt - t0), 4);
    check(32'(adc_trig[2:1]), 0);
    meas(1, 40);
    check(hi, 40);
    meas(2, 64);
    check(hi, 40);
    check(ri, 4);
    meas(3, 64);
    check(hi, 64);
    meas(4, 40);
    check(hi, 16);
    meas(5, 40);
    check(hi, 4);
    check(32'(shoot_q), 0);
    wr(12'h00c, 32'h1, 2'b00);
    meas(0, 40);
    check(hi, 16);
    wr(12'h058, 32'h2, 2'b00);
    repeat (20) @(posedge ref_clk);
    meas(0, 40);
    check(hi, 8);
    wr(12'h040, 32'h9, 2'b00);
    wr(12'h058, 32'h4, 2'b00);
    repeat (20) @(posedge ref_clk);
    meas(0, 40);
    check(hi, 8);
    wr(12'h000, 32'h1, 2'b00);
    repeat (20) @(posedge ref_clk);
    meas(0, 40);
    check(hi, 16);
    rv = $random(seed);
    wr(12'h06c, rv, 2'b00);
    rd(12'h06c, rv & 32'hfff, 2'b00, 1'b1);
    rd(12'h008, 32'h3f, 2'b00, 1'b1);
    wr(12'h100, 32'h0, 2'b10);
    rd(12'h100, 32'h0, 2'b10, 1'b0);
    dbg_stall <= 1'b1;
    repeat (30) @(posedge ref_clk);
    t0 = trig_cnt;
    meas(0, 30);
    check(ri, 0);
    check(32'(trig_cnt - t0), 0);
    check(32'(irq), 0);
    dbg_stall <= 1'b0;
    wr(12'h010, 32'h3f, 2'b00);
    wr(12'h014, 32'h10000, 2'b00);
    fault_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check(32'(pwm_out), 32'h1);
    check(32'(irq), 1);
    rd(12'h018, 32'h10000, 2'b00, 1'b1);
    fault_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    wr(12'h01c, 32'h10000, 2'b00);
    @(posedge ref_clk);
    check(32'(irq), 0);
    wr(12'h008, 32'h3d, 2'b00);
    repeat (4) @(posedge ref_clk);
    check(32'(pwm_out[1]), 0);
    repeat (4) @(posedge ref_clk);
    summarize();
  end
endmodule // tb_pwm_generator_module
`default_nettype wire
